// file: logic/dio_pad_drive.sv
`timescale 1ns/1ps
`default_nettype none
module dio_pad_drive
#(
   parameter int W        = 2,
   parameter bit PULL_FIT = 1'b1
)
(
   input  wire logic pclk,
   input  wire logic presetn,
   dio_pad_if.pad    io
);
   if (W < 1)
   begin : g_chk
      $error("dio_pad_drive: W must be at least 1");
   end

   // Open-drain lines only sink; a high latch releases the pin
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         io.pin_out <= '0;
         io.pin_oe  <= '0;
      end
      else if (io.push_pull)
      begin
         io.pin_out <= io.latch;
         io.pin_oe  <= io.dir;
      end
      else
      begin
         io.pin_out <= '0;
         io.pin_oe  <= io.dir & ~io.latch;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         io.pull_en <= {W{PULL_FIT}};
      else
         io.pull_en <= {W{PULL_FIT}} & ~io.dir;
   end
endmodule
`default_nettype wire

// file: logic/dio_pad_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dio_pad_if #(parameter int W = 2) ();
   logic [W-1:0] dir;
   logic [W-1:0] latch;
   logic         push_pull;
   logic [W-1:0] pin_out;
   logic [W-1:0] pin_oe;
   logic [W-1:0] pull_en;
   modport ctrl (output dir, latch, push_pull, input pin_out, pin_oe, pull_en);
   modport pad  (input dir, latch, push_pull, output pin_out, pin_oe, pull_en);
endinterface
`default_nettype wire

// file: logic/dio_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dio_pin_sync
#(
   parameter int W = 8
)
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] pin_in,
   output var  logic [W-1:0] level_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   if (W < 1)
   begin : g_chk
      $error("dio_pin_sync: W must be at least 1");
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A bit only moves once two stages agree, so a lone glitch is ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         level_q <= '0;
      else
         level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
   end
endmodule
`default_nettype wire

// file: logic/dio_pkg.sv
`default_nettype none
package dio_pkg;
   // Register map, one aligned 32-bit word each
   localparam logic [7:0] OFF_NARROW_DATA = 8'h00;
   localparam logic [7:0] OFF_NARROW_MODE = 8'h04;
   localparam logic [7:0] OFF_WIDE_DATA   = 8'h08;
   localparam logic [7:0] OFF_WIDE_MODE   = 8'h0c;
   localparam logic [7:0] OFF_WAKE_CTRL   = 8'h10;
   localparam logic [7:0] OFF_STATUS      = 8'h14;

   localparam int NARROW_W = 2;
   localparam int WIDE_W   = 8;

   // wide_port_mode_reg layout: [7:0] direction (1 = output), [8] push-pull
   localparam int WMODE_PP_BIT = 8;
   localparam int WMODE_W      = 9;

   // Wake control layout
   localparam int WCTL_OR_EN   = 0;
   localparam int WCTL_AND_EN  = 1;
   localparam int WCTL_EDGE_EN = 2;
   localparam int WCTL_W       = 3;

   // Status layout
   localparam int STAT_OR   = 0;
   localparam int STAT_AND  = 1;
   localparam int STAT_WAKE = 2;
   localparam int STAT_EDGE = 3;

   localparam logic [1:0]         RST_NARROW_MODE = 2'h0;
   localparam logic [1:0]         RST_NARROW_DATA = 2'h0;
   localparam logic [7:0]         RST_WIDE_DATA   = 8'h00;
   localparam logic [WMODE_W-1:0] RST_WIDE_MODE   = 9'h000;
   localparam logic [WCTL_W-1:0]  RST_WAKE_CTRL   = 3'h0;
endpackage
`default_nettype wire

// file: logic/dio_port_top.sv
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module dio_port_top
   import dio_pkg::*;
#(
   parameter int ADDR_W          = 8,
   parameter bit NARROW_PULL_FIT = 1'b1,
   parameter bit WIDE_PULL_FIT   = 1'b1
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   input  wire logic              stop_recover,
   input  wire logic [1:0]        narrow_pin_in,
   output wire logic [1:0]        narrow_pin_out,
   output wire logic [1:0]        narrow_pin_oe,
   output wire logic [1:0]        narrow_pull_en,
   input  wire logic [7:0]        wide_pin_in,
   output wire logic [7:0]        wide_pin_out,
   output wire logic [7:0]        wide_pin_oe,
   output wire logic [7:0]        wide_pull_en,
   output var  logic              wake_req,
   output var  logic              edge_src
);
   if (ADDR_W < 8 || ADDR_W > 32)
   begin : g_chk
      $error("dio_port_top: ADDR_W must lie in 8..32");
   end

   logic [1:0]         narrow_mode_q;
   logic [1:0]         narrow_dat_q;
   logic [7:0]         wide_dat_q;
   logic [WMODE_W-1:0] wide_mode_q;
   logic [WCTL_W-1:0]  wake_ctl_q;
   logic [1:0]         narrow_sync;
   logic [7:0]         wide_sync;
   logic               gate_or;
   logic               gate_and;
   logic [31:0]        rdata_d;
   logic               hit_d;
   logic               setup;
   logic               wr_en;
   logic [1:0]         narrow_view;
   logic [7:0]         wide_view;

   dio_pad_if #(.W(NARROW_W)) narrow_io ();
   dio_pad_if #(.W(WIDE_W))   wide_io ();

   dio_pin_sync #(.W(NARROW_W)) u_narrow_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (narrow_pin_in),
      .level_q (narrow_sync)
   );

   dio_pin_sync #(.W(WIDE_W)) u_wide_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (wide_pin_in),
      .level_q (wide_sync)
   );

   dio_pad_drive #(.W(NARROW_W), .PULL_FIT(NARROW_PULL_FIT)) u_narrow_pad
   (
      .pclk    (pclk),
      .presetn (presetn),
      .io      (narrow_io.pad)
   );

   dio_pad_drive #(.W(WIDE_W), .PULL_FIT(WIDE_PULL_FIT)) u_wide_pad
   (
      .pclk    (pclk),
      .presetn (presetn),
      .io      (wide_io.pad)
   );

   // The narrow port has no open-drain choice
   assign narrow_io.dir       = narrow_mode_q;
   assign narrow_io.latch     = narrow_dat_q;
   assign narrow_io.push_pull = 1'b1;
   // Wide port has no alternate function, so its pads always follow the registers
   assign wide_io.dir         = wide_mode_q[7:0];
   assign wide_io.latch       = wide_dat_q;
   assign wide_io.push_pull   = wide_mode_q[WMODE_PP_BIT];

   assign narrow_pin_out = narrow_io.pin_out;
   assign narrow_pin_oe  = narrow_io.pin_oe;
   assign narrow_pull_en = narrow_io.pull_en;
   assign wide_pin_out   = wide_io.pin_out;
   assign wide_pin_oe    = wide_io.pin_oe;
   assign wide_pull_en   = wide_io.pull_en;

   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite;

   // Outputs show the latch; inputs show the settled pin
   assign narrow_view = (narrow_mode_q & narrow_dat_q) | (~narrow_mode_q & narrow_sync);
   assign wide_view   = (wide_mode_q[7:0] & wide_dat_q) | (~wide_mode_q[7:0] & wide_sync);

   assign gate_or  = |wide_sync;
   assign gate_and = &wide_sync;

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      hit_d   = 1'b1;
      unique case (paddr)
         ADDR_W'(OFF_NARROW_DATA): rdata_d[1:0]         = narrow_view;
         ADDR_W'(OFF_NARROW_MODE): rdata_d[1:0]         = narrow_mode_q;
         ADDR_W'(OFF_WIDE_DATA):   rdata_d[7:0]         = wide_view;
         ADDR_W'(OFF_WIDE_MODE):   rdata_d[WMODE_W-1:0] = wide_mode_q;
         ADDR_W'(OFF_WAKE_CTRL):   rdata_d[WCTL_W-1:0]  = wake_ctl_q;
         ADDR_W'(OFF_STATUS):
         begin
            rdata_d[STAT_OR]   = gate_or;
            rdata_d[STAT_AND]  = gate_and;
            rdata_d[STAT_WAKE] = wake_req;
            rdata_d[STAT_EDGE] = edge_src;
         end
         default:                  hit_d                = 1'b0;
      endcase
   end

   // Every access takes exactly one access cycle; read data is captured at setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= setup;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
         pslverr <= ~hit_d;
      end
      else if (!psel)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // Recovery from stop clears the narrow port but not the wide mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         narrow_mode_q <= RST_NARROW_MODE;
         narrow_dat_q  <= RST_NARROW_DATA;
      end
      else if (stop_recover)
      begin
         narrow_mode_q <= RST_NARROW_MODE;
         narrow_dat_q  <= RST_NARROW_DATA;
      end
      else if (wr_en && pstrb[0])
      begin
         if (paddr == ADDR_W'(OFF_NARROW_MODE))
            narrow_mode_q <= pwdata[1:0];
         if (paddr == ADDR_W'(OFF_NARROW_DATA))
            narrow_dat_q <= pwdata[1:0];
      end
   end

   // Survives stop recovery on purpose
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wide_mode_q <= RST_WIDE_MODE;
      else if (wr_en && paddr == ADDR_W'(OFF_WIDE_MODE))
      begin
         if (pstrb[0])
            wide_mode_q[7:0] <= pwdata[7:0];
         if (pstrb[1])
            wide_mode_q[WMODE_PP_BIT] <= pwdata[WMODE_PP_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wide_dat_q <= RST_WIDE_DATA;
      else if (wr_en && pstrb[0] && paddr == ADDR_W'(OFF_WIDE_DATA))
         wide_dat_q <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wake_ctl_q <= RST_WAKE_CTRL;
      else if (stop_recover)
         wake_ctl_q <= RST_WAKE_CTRL;
      else if (wr_en && pstrb[0] && paddr == ADDR_W'(OFF_WAKE_CTRL))
         wake_ctl_q <= pwdata[WCTL_W-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wake_req <= 1'b0;
      else
         wake_req <= (wake_ctl_q[WCTL_OR_EN] & gate_or) | (wake_ctl_q[WCTL_AND_EN] & gate_and);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         edge_src <= 1'b0;
      else
         edge_src <= wake_ctl_q[WCTL_EDGE_EN] & wide_sync[0];
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Pads and the wake and edge outputs sit one flop behind their sources, so drive checks look one edge back

   a_narrow_push_pull: assert property
      (narrow_pin_oe == $past(narrow_mode_q) &&
       (narrow_pin_out & narrow_pin_oe) == ($past(narrow_dat_q) & narrow_pin_oe))
      else $error("narrow port drive does not follow mode and latch");

   a_narrow_mode_write: assert property
      (wr_en && pstrb[0] && !stop_recover && paddr == ADDR_W'(OFF_NARROW_MODE)
       |-> ##2 narrow_pin_oe == $past(pwdata[1:0], 2))
      else $error("narrow direction write did not reach the pins");

   a_narrow_reset_in: assert property
      (!$past(presetn) |->
       narrow_pin_oe == 2'h0 && narrow_mode_q == RST_NARROW_MODE)
      else $error("narrow port driving straight after reset");

   a_narrow_pull_off: assert property
      ((narrow_pull_en & $past(narrow_mode_q)) == 2'h0 &&
       (narrow_pull_en | $past(narrow_mode_q)) == ({2{NARROW_PULL_FIT}} | $past(narrow_mode_q)))
      else $error("narrow pull-up on while line is an output");

   a_wide_dir_bits: assert property
      ($past(wide_mode_q[WMODE_PP_BIT]) |-> wide_pin_oe == $past(wide_mode_q[7:0]))
      else $error("wide push-pull enables differ from direction bits");

   a_wide_open_drain: assert property
      (!$past(wide_mode_q[WMODE_PP_BIT]) |->
       wide_pin_out == 8'h00 && wide_pin_oe == ($past(wide_mode_q[7:0]) & ~$past(wide_dat_q)))
      else $error("wide open-drain line drives high");

   a_wide_reset_cfg: assert property
      (!$past(presetn) |-> wide_mode_q == RST_WIDE_MODE && wide_pin_oe == 8'h00)
      else $error("wide port not input and open-drain after reset");

   a_wake_gate: assert property
      (wake_req == ($past(wake_ctl_q[WCTL_OR_EN] && wide_sync != 8'h00) ||
                    $past(wake_ctl_q[WCTL_AND_EN] && wide_sync == 8'hff)))
      else $error("wake request does not match its gates");

   a_edge_route: assert property
      (edge_src == $past(wake_ctl_q[WCTL_EDGE_EN] && wide_sync[0]))
      else $error("edge source active while not routed");

   a_mode_keeps: assert property
      (stop_recover && !wr_en |=> $stable(wide_mode_q))
      else $error("stop recovery altered wide mode register");

   a_read_view: assert property
      (setup && !pwrite && paddr == ADDR_W'(OFF_WIDE_DATA) |=>
       prdata[7:0] == $past(wide_view) && pready && !pslverr)
      else $error("wide data read returned wrong mix");

   a_wide_push_out: assert property
      ($past(wide_mode_q[WMODE_PP_BIT]) |->
       (wide_pin_out & wide_pin_oe) == ($past(wide_dat_q) & wide_pin_oe))
      else $error("wide push-pull line does not show its latch");

   a_wide_mode_write: assert property
      (wr_en && pstrb[0] && paddr == ADDR_W'(OFF_WIDE_MODE) |=>
       wide_mode_q[7:0] == $past(pwdata[7:0]))
      else $error("wide direction write did not land");

   a_wide_input_idle: assert property
      ((wide_pin_oe & ~$past(wide_mode_q[7:0])) == 8'h00)
      else $error("wide input line is being driven");

   a_narrow_read_view: assert property
      (setup && !pwrite && paddr == ADDR_W'(OFF_NARROW_DATA) |=>
       prdata[1:0] == $past((narrow_mode_q & narrow_dat_q) | (~narrow_mode_q & narrow_sync)) &&
       pready && !pslverr)
      else $error("narrow data read returned wrong mix");

   a_edge_follow: assert property
      (wake_ctl_q[WCTL_EDGE_EN] && wide_sync[0] |=> edge_src)
      else $error("routed edge line did not reach the edge source");

   a_wake_or_path: assert property
      (wake_ctl_q[WCTL_OR_EN] && wide_sync != 8'h00 |=> wake_req)
      else $error("enabled OR gate did not raise wake");

   c_wide_output: cover property
      (wr_en && paddr == ADDR_W'(OFF_WIDE_MODE) ##2 wide_pin_oe != 8'h00);
   c_wake: cover property
      ($rose(wake_req));
   c_edge: cover property
      ($rose(edge_src));
   c_recover: cover property
      (stop_recover && wide_mode_q != RST_WIDE_MODE);
   c_open_drain: cover property
      (!wide_mode_q[WMODE_PP_BIT] && wide_pin_oe != 8'h00);
endmodule
`default_nettype wire

// file: verif/dio_board_model.sv
`timescale 1ns/1ps
`default_nettype none
// Board side of one port: pads, resistors and whatever the bench drives onto the lines
module dio_board_model
#(
   parameter int W = 2
)
(
   input  wire logic         pclk,
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe,
   input  wire logic [W-1:0] pull_en,
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   output wire logic [W-1:0] pin_in
);
   logic flip_q = 1'b0;

   // A floating line wanders, so it must never read as a steady level
   always_ff @(posedge pclk)
   begin
      flip_q <= ~flip_q;
   end

   assign pin_in = (pin_oe & pin_out)
                 | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & pull_en)
                 | (~pin_oe & ~ext_en & ~pull_en & {W{flip_q}});
endmodule
`default_nettype wire

// file: verif/test_dual_io_port_block.sv
`timescale 1ns/1ps
`default_nettype none
module test_dual_io_port_block
   import dio_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, stop_recover;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, wake_req, edge_src;
   logic [1:0]  narrow_pin_in, narrow_pin_out, narrow_pin_oe, narrow_pull_en, n_ext;
   logic [7:0]  wide_pin_in, wide_pin_out, wide_pin_oe, wide_pull_en, w_ext, w_en;
   logic [32:0] exp_q[$];
   logic [32:0] mon_e;
   logic [31:0] m, l, v, oe;
   logic        pp;
   int          fails, comparisons, c;

   dio_port_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .stop_recover(stop_recover),
      .narrow_pin_in(narrow_pin_in), .narrow_pin_out(narrow_pin_out),
      .narrow_pin_oe(narrow_pin_oe), .narrow_pull_en(narrow_pull_en),
      .wide_pin_in(wide_pin_in), .wide_pin_out(wide_pin_out), .wide_pin_oe(wide_pin_oe),
      .wide_pull_en(wide_pull_en), .wake_req(wake_req), .edge_src(edge_src));

   dio_board_model #(.W(2)) nb (.pclk(pclk), .pin_out(narrow_pin_out), .pin_oe(narrow_pin_oe),
      .pull_en(narrow_pull_en), .ext_en(2'h3), .ext_val(n_ext), .pin_in(narrow_pin_in));
   dio_board_model #(.W(8)) wb (.pclk(pclk), .pin_out(wide_pin_out), .pin_oe(wide_pin_oe),
      .pull_en(wide_pull_en), .ext_en(w_en), .ext_val(w_ext), .pin_in(wide_pin_in));

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want)
      begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask

   task automatic tally_and_finish;
      if (fails == 0 && comparisons > 0 && exp_q.size() == 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // The watcher owns every bus comparison, so a late or missing answer still shows
   always @(posedge pclk)
   begin
      if (pready === 1'b1)
      begin
         mon_e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_ffff_ffff;
         check(prdata, mon_e[31:0]);
         check({31'h0, pslverr}, {31'h0, mon_e[32]});
      end
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      int n;
      exp_q.push_back(e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         fails++;
         tally_and_finish();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask

   // Pins need about five edges through the synchroniser; eight leaves margin
   task automatic settle;
      repeat (8) @(posedge pclk);
   endtask

   initial
   begin
      {presetn, psel, penable, pwrite, stop_recover} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_ext = 2'h0;
      w_ext = 8'h00;
      w_en = 8'hff;
      fails = 0;
      comparisons = 0;
      void'($urandom(84641));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      check({12'h0, narrow_pin_oe, narrow_pull_en, wide_pin_oe, wide_pull_en},
            32'h0003_00ff);
      rd(OFF_NARROW_MODE, 32'h0);
      rd(OFF_WIDE_MODE, 32'h0);
      rd(OFF_WAKE_CTRL, 32'h0);
      rd(OFF_NARROW_DATA, 32'h0);
      rd(OFF_STATUS, 32'h0);
      apb(1'b1, 8'h18, 32'h5, 33'h1_0000_0000);
      apb(1'b0, 8'h18, 32'h0, 33'h1_0000_0000);
      for (c = 0; c < 8; c++)
      begin
         m = $urandom & 32'h3;
         l = $urandom & 32'h3;
         n_ext <= 2'($urandom);
         wr(OFF_NARROW_MODE, m);
         wr(OFF_NARROW_DATA, l);
         settle();
         check({30'h0, narrow_pin_oe}, m);
         check({30'h0, narrow_pin_out & narrow_pin_oe}, l & m);
         check({30'h0, narrow_pull_en}, ~m & 32'h3);
         rd(OFF_NARROW_DATA, (m & l) | (~m & {30'h0, n_ext}));
      end
      for (c = 0; c < 8; c++)
      begin
         m = $urandom & 32'hff;
         l = $urandom & 32'hff;
         pp = c[0];
         w_ext <= 8'($urandom);
         wr(OFF_WIDE_MODE, {23'h0, pp, m[7:0]});
         wr(OFF_WIDE_DATA, l);
         settle();
         oe = pp ? m : (m & ~l);
         check({24'h0, wide_pin_oe}, oe);
         check({24'h0, wide_pin_out} & oe, pp ? (l & oe) : 32'h0);
         check({24'h0, wide_pull_en}, ~m & 32'hff);
         rd(OFF_WIDE_DATA, (m & l) | (~m & {24'h0, w_ext}));
      end
      wr(OFF_WIDE_MODE, 32'h0);
      for (c = 0; c < 8; c++)
      begin
         v = (c % 4 == 0) ? 32'h00 : (c % 4 == 1) ? 32'hff : (c % 4 == 2) ? 32'h01 : $urandom;
         w_ext <= v[7:0];
         wr(OFF_WAKE_CTRL, c);
         settle();
         l = {28'h0, c[2] & v[0], (c[0] & |v[7:0]) | (c[1] & &v[7:0]), &v[7:0], |v[7:0]};
         check({30'h0, wake_req, edge_src}, {30'h0, l[2], l[3]});
         rd(OFF_STATUS, l);
      end
      wr(OFF_NARROW_MODE, 32'h3);
      wr(OFF_WIDE_MODE, 32'h1a5);
      wr(OFF_WIDE_DATA, 32'h3c);
      stop_recover <= 1'b1;
      @(posedge pclk);
      stop_recover <= 1'b0;
      settle();
      rd(OFF_NARROW_MODE, 32'h0);
      rd(OFF_WIDE_MODE, 32'h1a5);
      rd(OFF_WIDE_DATA, 32'h24 | (~32'ha5 & {24'h0, w_ext}));
      rd(OFF_WAKE_CTRL, 32'h0);
      check({24'h0, wide_pin_oe}, 32'ha5);
      // Released inputs must read high through the pull-ups left on for input lines
      w_en <= 8'h00;
      settle();
      rd(OFF_WIDE_DATA, 32'h7e);
      tally_and_finish();
   end
endmodule
`default_nettype wire
